// ==== inc/sfa_defines.vh ====
`ifndef SFA_DEFINES_VH
`define SFA_DEFINES_VH

// APB byte offsets of the register words
`define SFA_OFS_PRESCALE      8'h00
`define SFA_OFS_CONTROL       8'h04
`define SFA_OFS_DATA          8'h08
`define SFA_OFS_STATUS        8'h0C
`define SFA_OFS_MASK          8'h10

// Prescale register fields
`define SFA_PS_SEL_HI         7
`define SFA_PS_SEL_LO         5
`define SFA_FINE_HI           4
`define SFA_FINE_LO           0
`define SFA_PS_BYPASS         3'h0
`define SFA_FRAME_LEN         5'h1F

// Arbiter control register bit positions
`define SFA_CTL_MODE_HI       7
`define SFA_CTL_LOST          6
`define SFA_CTL_MODE_LO       5
`define SFA_CTL_ACLK          4
`define SFA_CTL_DONE          3
`define SFA_CTL_RUN           2
`define SFA_CTL_OVF           1
`define SFA_CTL_MSB           0

// Arbiter modes
`define SFA_MODE_IDLE         2'h0
`define SFA_MODE_MEASURE      2'h1
`define SFA_MODE_ARBITRATE    2'h2

// Interrupt status and mask bit positions
`define SFA_IRQ_DONE          0
`define SFA_IRQ_LOST          1
`define SFA_IRQ_OVF           2
`define SFA_IRQ_W             3

// Reset values
`define SFA_RST_PRESCALE      8'h00
`define SFA_RST_MODE          2'h0
`define SFA_RST_MASK          3'h0

// Arbitration sample points in counter ticks
`define SFA_SAMPLE_BUS        9'h038
`define SFA_SAMPLE_PRESC      9'h008

`endif

// ==== hdl/sfa_fracdiv.v ====
`timescale 1ns/1ps
`default_nettype none
`include "sfa_defines.vh"

module sfa_fracdiv (
   input  wire       sys_clk,
   input  wire       rst_n,
   input  wire       ce,
   input  wire [2:0] ps_sel,
   input  wire [4:0] fine,
   output reg        tick_reg
);
   reg  [3:0] cnt_reg;
   reg  [4:0] frame_reg;
   wire [3:0] len;
   wire       last;

   // Output period is divisor plus one extra input clock in the first n periods of each frame
   assign len  = {1'b0, ps_sel} + ((frame_reg < fine) ? 4'h2 : 4'h1);
   assign last = (cnt_reg == len - 4'h1);

   // Divider state; bypass gives a tick every bus clock and ignores the fine field
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg   <= 4'h0;
         frame_reg <= 5'h00;
         tick_reg  <= 1'b0;
      end else if (ce) begin
         if (ps_sel == `SFA_PS_BYPASS) begin
            cnt_reg   <= 4'h0;
            frame_reg <= 5'h00;
            tick_reg  <= 1'b1;
         end else if (last) begin
            cnt_reg   <= 4'h0;
            frame_reg <= frame_reg + 5'h01;
            tick_reg  <= 1'b1;
         end else begin
            cnt_reg  <= cnt_reg + 4'h1;
            tick_reg <= 1'b0;
         end
      end
   end
endmodule // sfa_fracdiv

`default_nettype wire

// ==== hdl/sfa_count9.v ====
`timescale 1ns/1ps
`default_nettype none

module sfa_count9 (
   input  wire       sys_clk,
   input  wire       rst_n,
   input  wire       ce,
   input  wire       clr,
   input  wire       inc,
   output reg  [8:0] count_reg,
   output wire       ovf
);
   // Carry out of the nine-bit counter
   assign ovf = inc && !clr && (count_reg == 9'h1FF);

   // Clear dominates counting
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         count_reg <= 9'h000;
      end else if (ce) begin
         if (clr) begin
            count_reg <= 9'h000;
         end else if (inc) begin
            count_reg <= count_reg + 9'h001;
         end
      end
   end
endmodule // sfa_count9

`default_nettype wire

// ==== hdl/sfa_arbiter.v ====
`timescale 1ns/1ps
`default_nettype none
`include "sfa_defines.vh"

module sfa_arbiter (
   input  wire        sys_clk,
   input  wire        rst_n,
   input  wire        ce,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        rxd_in,
   input  wire        tx_internal,
   output reg         txd_out,
   output reg         irq
);
   // Arbiter sequencing states
   localparam ST_IDLE   = 2'h0;
   localparam ST_RUN    = 2'h1;
   localparam ST_WAIT   = 2'h2;
   localparam ST_STOP   = 2'h3;

   reg  [7:0]  prescale_reg;
   reg  [1:0]  mode_reg;
   reg         aclk_reg;
   reg         lost_reg;
   reg         done_reg;
   reg         ovf_reg;
   reg  [1:0]  state_reg;
   reg  [1:0]  state_next;
   reg         half_reg;
   reg         rxd_prev_reg;
   reg         tx_prev_reg;
   reg  [2:0]  status_reg;
   reg  [2:0]  mask_reg;
   reg  [7:0]  ctl_rd;
   reg  [31:0] rd_mux;
   reg         hit;
   reg         cnt_clr;
   reg         set_done;
   reg         set_lost;

   wire        setup;
   wire        access;
   wire        wr;
   wire        rd;
   wire        wr_ctl;
   wire        rd_status;
   wire        presc_tick;
   wire        src_tick;
   wire        cnt_inc;
   wire [8:0]  count;
   wire        cnt_ovf;
   wire        rx_fall;
   wire        rx_rise;
   wire        tx_rise;
   wire [8:0]  sample_pt;
   wire        running;
   wire [2:0]  events;

   // APB phase decode
   assign setup     = psel && !penable;
   assign access    = psel && penable && pready;
   assign wr        = access && pwrite;
   assign rd        = access && !pwrite;
   assign wr_ctl    = wr && (paddr == `SFA_OFS_CONTROL);
   assign rd_status = rd && (paddr == `SFA_OFS_STATUS);

   // Fractional prescaler producing the serial input clock enable
   sfa_fracdiv u_fracdiv (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .ce       (ce),
      .ps_sel   (prescale_reg[`SFA_PS_SEL_HI:`SFA_PS_SEL_LO]),
      .fine     (prescale_reg[`SFA_FINE_HI:`SFA_FINE_LO]),
      .tick_reg (presc_tick)
   );

   // Counter advances on every second tick of the selected source
   assign src_tick = aclk_reg ? presc_tick : 1'b1;
   assign running  = (state_reg == ST_RUN);
   assign cnt_inc  = running && src_tick && half_reg;

   // Nine-bit arbiter counter with carry
   sfa_count9 u_count9 (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .ce        (ce),
      .clr       (cnt_clr),
      .inc       (cnt_inc),
      .count_reg (count),
      .ovf       (cnt_ovf)
   );

   // Line edges
   assign rx_fall   = rxd_prev_reg && !rxd_in;
   assign rx_rise   = !rxd_prev_reg && rxd_in;
   assign tx_rise   = !tx_prev_reg && tx_internal;
   assign sample_pt = aclk_reg ? `SFA_SAMPLE_PRESC : `SFA_SAMPLE_BUS;

   // Sequencer: next state, counter clear and event strobes
   always @* begin
      state_next = state_reg;
      cnt_clr    = wr_ctl;
      set_done   = 1'b0;
      set_lost   = 1'b0;
      case (mode_reg)
         `SFA_MODE_IDLE: begin
            state_next = ST_IDLE;
            cnt_clr    = 1'b1;
         end
         `SFA_MODE_MEASURE: begin
            case (state_reg)
               ST_IDLE: begin
                  if (aclk_reg ? !rxd_in : rx_fall) begin
                     state_next = ST_RUN;
                  end
               end
               ST_RUN: begin
                  if (aclk_reg ? rx_rise : rx_fall) begin
                     state_next = ST_STOP;
                     set_done   = 1'b1;
                  end
               end
               default: begin
                  state_next = ST_STOP;
               end
            endcase
         end
         `SFA_MODE_ARBITRATE: begin
            case (state_reg)
               ST_IDLE, ST_STOP, ST_WAIT: begin
                  if (tx_rise) begin
                     state_next = ST_RUN;
                     cnt_clr    = 1'b1;
                  end
               end
               ST_RUN: begin
                  if (count == sample_pt) begin
                     state_next = ST_STOP;
                     set_lost   = !rxd_in;
                  end else if (!tx_internal) begin
                     state_next = ST_WAIT;
                     cnt_clr    = 1'b1;
                  end
               end
               default: begin
                  state_next = ST_IDLE;
               end
            endcase
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // Sequencer state and edge history
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg    <= ST_IDLE;
         half_reg     <= 1'b0;
         rxd_prev_reg <= 1'b1;
         tx_prev_reg  <= 1'b1;
      end else if (ce) begin
         state_reg    <= state_next;
         rxd_prev_reg <= rxd_in;
         tx_prev_reg  <= tx_internal;
         if (!running) begin
            half_reg <= 1'b0;
         end else if (src_tick) begin
            half_reg <= !half_reg;
         end
      end
   end

   // Control register and flags; an event beats a clear in the same cycle
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         prescale_reg <= `SFA_RST_PRESCALE;
         mode_reg     <= `SFA_RST_MODE;
         aclk_reg     <= 1'b0;
         lost_reg     <= 1'b0;
         done_reg     <= 1'b0;
         ovf_reg      <= 1'b0;
         mask_reg     <= `SFA_RST_MASK;
      end else if (ce) begin
         if (wr && paddr == `SFA_OFS_PRESCALE) begin
            prescale_reg <= pwdata[7:0];
         end
         if (wr && paddr == `SFA_OFS_MASK) begin
            mask_reg <= pwdata[`SFA_IRQ_W-1:0];
         end
         if (wr_ctl) begin
            mode_reg <= {pwdata[`SFA_CTL_MODE_HI], pwdata[`SFA_CTL_MODE_LO]};
            aclk_reg <= pwdata[`SFA_CTL_ACLK];
         end
         if (set_lost) begin
            lost_reg <= 1'b1;
         end else if (wr_ctl && !pwdata[`SFA_CTL_MODE_HI]) begin
            lost_reg <= 1'b0;
         end
         if (set_done) begin
            done_reg <= 1'b1;
         end else if (wr_ctl) begin
            done_reg <= 1'b0;
         end
         if (cnt_ovf) begin
            ovf_reg <= 1'b1;
         end else if (wr_ctl) begin
            ovf_reg <= 1'b0;
         end
      end
   end

   // Events for the interrupt status register
   assign events = {cnt_ovf, set_lost, set_done};

   // Sticky status, cleared by a read; a new event in the read cycle survives
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         status_reg <= 3'h0;
         irq        <= 1'b0;
      end else if (ce) begin
         status_reg <= (rd_status ? 3'h0 : status_reg) | events;
         irq        <= |(status_reg & mask_reg);
      end
   end

   // Transmit pin forced high while arbitration is lost and the mode is arbitrate
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         txd_out <= 1'b1;
      end else if (ce) begin
         txd_out <= tx_internal || (lost_reg && mode_reg == `SFA_MODE_ARBITRATE);
      end
   end

   // Read view of the control register
   always @* begin
      ctl_rd                   = 8'h00;
      ctl_rd[`SFA_CTL_MODE_HI] = mode_reg[1];
      ctl_rd[`SFA_CTL_LOST]    = lost_reg;
      ctl_rd[`SFA_CTL_MODE_LO] = mode_reg[0];
      ctl_rd[`SFA_CTL_ACLK]    = aclk_reg;
      ctl_rd[`SFA_CTL_DONE]    = done_reg;
      ctl_rd[`SFA_CTL_RUN]     = running;
      ctl_rd[`SFA_CTL_OVF]     = ovf_reg;
      ctl_rd[`SFA_CTL_MSB]     = count[8];
   end

   // Address decode for reads
   always @* begin
      rd_mux = 32'h0000_0000;
      hit    = 1'b1;
      case (paddr)
         `SFA_OFS_PRESCALE: rd_mux = {24'h00_0000, prescale_reg};
         `SFA_OFS_CONTROL:  rd_mux = {24'h00_0000, ctl_rd};
         `SFA_OFS_DATA:     rd_mux = {24'h00_0000, count[7:0]};
         `SFA_OFS_STATUS:   rd_mux = {29'h0000_0000, status_reg};
         `SFA_OFS_MASK:     rd_mux = {29'h0000_0000, mask_reg};
         default:           hit    = 1'b0;
      endcase
   end

   // APB answer: one access cycle after each setup, data latched in setup
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else if (ce) begin
         pready  <= setup;
         pslverr <= setup && !hit;
         if (setup && !pwrite) begin
            prdata <= rd_mux;
         end
      end
   end
endmodule // sfa_arbiter

`default_nettype wire

// ==== verif/sfa_node_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// Other node on the shared line, pulling it dominant low on command
module sfa_node_model (
   input  wire logic txd_out,
   input  wire logic pull_low,
   output logic      rxd_in
);
   // Wired-AND line with pull-up: either node may force it low
   assign rxd_in = txd_out & ~pull_low;
endmodule // sfa_node_model

`default_nettype wire

// ==== verif/sfa_arbiter_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sfa_defines.vh"

module sfa_arbiter_properties (
   input wire logic        sys_clk,
   input wire logic        rst_n,
   input wire logic        ce,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        rxd_in,
   input wire logic        tx_internal,
   input wire logic        txd_out,
   input wire logic        irq
);
   logic [1:0] mode_reg;
   logic [2:0] mask_reg;
   logic       wr_done;
   // Shadow of the mode and mask as software last wrote them
   assign wr_done = ce & psel & penable & pready & pwrite;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_reg <= 2'h0;
         mask_reg <= 3'h0;
      end else if (wr_done && paddr == `SFA_OFS_CONTROL) begin
         mode_reg <= {pwdata[7], pwdata[5]};
      end else if (wr_done && paddr == `SFA_OFS_MASK) begin
         mask_reg <= pwdata[2:0];
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   chk_ready_after_setup: assert property (ce && psel && !penable |=> pready)
      else $error("no ready after setup");
   chk_ready_one_cycle: assert property (pready |=> !pready)
      else $error("ready held too long");
   chk_unmapped_err: assert property (pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10}))
      else $error("error response wrong");
   chk_err_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read not zero");
   chk_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
      else $error("upper read bits set");
   chk_tx_only_high: assert property (!txd_out |-> !$past(tx_internal))
      else $error("transmit pin forced low");
   chk_tx_follows: assert property (mode_reg != 2'h2 && $past(mode_reg) != 2'h2 |-> txd_out == $past(tx_internal))
      else $error("transmit pin not following");
   chk_irq_masked: assert property (mask_reg == 3'h0 && $past(mask_reg) == 3'h0 |-> !irq)
      else $error("irq with all masked");

   cover property (txd_out && !tx_internal && mode_reg == 2'h2);
   cover property (irq);
   cover property (pready && pslverr);
endmodule // sfa_arbiter_properties

`default_nettype wire

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none

module testbench;
   typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} sfa_row_t;
   logic        sys_clk, rst_n, ce, psel, penable, pwrite, tx_internal, pull_low;
   logic        pready, pslverr, txd_out, irq, rxd_in, er;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   int          miscompares, n_checks, cycles, i;
   // Register cases: write, address, data, expected read, expected error
   sfa_row_t    rows [14] = '{
      '{0, 8'h00, 32'h0, 32'h00, 0}, '{1, 8'h00, 32'hFF, 32'h0, 0}, '{0, 8'h00, 32'h0, 32'hFF, 0},
      '{0, 8'h10, 32'h0, 32'h00, 0}, '{1, 8'h10, 32'h07, 32'h0, 0}, '{0, 8'h10, 32'h0, 32'h07, 0},
      '{0, 8'h14, 32'h0, 32'h00, 1}, '{1, 8'h20, 32'h55, 32'h0, 1}, '{0, 8'h04, 32'h0, 32'h00, 0},
      '{1, 8'h04, 32'h10, 32'h0, 0}, '{0, 8'h04, 32'h0, 32'h10, 0}, '{1, 8'h04, 32'h4E, 32'h0, 0},
      '{0, 8'h04, 32'h0, 32'h00, 0}, '{0, 8'h08, 32'h0, 32'h00, 0}};

   sfa_arbiter uut (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rxd_in(rxd_in), .tx_internal(tx_internal), .txd_out(txd_out), .irq(irq));
   sfa_node_model node (.txd_out(txd_out), .pull_low(pull_low), .rxd_in(rxd_in));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One APB transfer; read data and error taken at the ready edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      // Waits until pready is seen high; the bench timeout ends it if pready never comes
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic idle(input int k);
      repeat (k) @(posedge sys_clk);
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   // Cuts a hang short
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         conclude();
      end
   end

   initial begin
      rst_n = 1'b0;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      tx_internal = 1'b1;
      pull_low = 1'b0;
      idle(20);
      rst_n <= 1'b1;
      for (i = 0; i < 14; i++) begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         check(er, rows[i].e);
         if (!rows[i].w) check(rd, rows[i].x);
      end
      $display("register table done");
      // Measurement between two falling edges at half bus clock
      apb(1, 8'h04, 32'h20);
      pull_low <= 1'b1;
      idle(20);
      pull_low <= 1'b0;
      apb(0, 8'h04, 32'h0);
      check(rd, 32'h24);
      idle(30);
      pull_low <= 1'b1;
      idle(4);
      apb(0, 8'h04, 32'h0);
      check(rd, 32'h28);
      apb(0, 8'h08, 32'h0);
      check(32'(rd >= 32'd20 && rd <= 32'd30), 32'h1);
      check(irq, 1'b1);
      apb(0, 8'h0C, 32'h0);
      check(rd, 32'h1);
      idle(3);
      check(irq, 1'b0);
      pull_low <= 1'b0;
      // A finished measurement is re-armed by passing through idle
      apb(1, 8'h04, 32'h00);
      apb(1, 8'h04, 32'h20);
      apb(0, 8'h04, 32'h0);
      check(rd, 32'h20);
      apb(0, 8'h08, 32'h0);
      check(rd, 32'h0);
      $display("measurement done");
      // Long run: counter MSB, then wrap with overflow
      pull_low <= 1'b1;
      idle(2);
      pull_low <= 1'b0;
      idle(600);
      apb(0, 8'h04, 32'h0);
      check(rd, 32'h25);
      idle(500);
      apb(0, 8'h04, 32'h0);
      check(rd, 32'h26);
      apb(0, 8'h0C, 32'h0);
      check(rd, 32'h4);
      apb(1, 8'h04, 32'h00);
      idle(50);
      apb(0, 8'h04, 32'h0);
      check(rd, 32'h0);
      apb(0, 8'h08, 32'h0);
      check(rd, 32'h0);
      $display("overflow done");
      // Arbitration won, then lost against a dominant node
      apb(1, 8'h04, 32'h80);
      tx_internal <= 1'b0;
      idle(4);
      tx_internal <= 1'b1;
      idle(150);
      apb(0, 8'h04, 32'h0);
      check(rd[6], 1'b0);
      tx_internal <= 1'b0;
      idle(4);
      tx_internal <= 1'b1;
      pull_low <= 1'b1;
      idle(150);
      pull_low <= 1'b0;
      apb(0, 8'h04, 32'h0);
      check(rd[6], 1'b1);
      tx_internal <= 1'b0;
      idle(3);
      check(txd_out, 1'b1);
      apb(1, 8'h04, 32'h80);
      apb(0, 8'h04, 32'h0);
      check(rd[6], 1'b1);
      apb(0, 8'h0C, 32'h0);
      check(rd[1], 1'b1);
      apb(1, 8'h04, 32'h00);
      apb(0, 8'h04, 32'h0);
      check(rd, 32'h0);
      check(txd_out, 1'b0);
      $display("arbitration done");
      // Own transmitter drops before the sample point: arbitration stops and waits for the next rise, nothing lost
      apb(1, 8'h04, 32'h80);
      tx_internal <= 1'b1;
      idle(20);
      tx_internal <= 1'b0;
      idle(150);
      apb(0, 8'h04, 32'h0);
      check(rd, 32'h80);
      $display("arbitration restart done");
      // Break length on the prescaled clock: divisor 2 with half a clock of fine adjust
      apb(1, 8'h04, 32'h00);
      tx_internal <= 1'b1;
      apb(1, 8'h00, 32'h30);
      apb(1, 8'h04, 32'h30);
      pull_low <= 1'b1;
      idle(400);
      pull_low <= 1'b0;
      idle(4);
      apb(0, 8'h04, 32'h0);
      check(rd, 32'h38);
      apb(0, 8'h08, 32'h0);
      check(32'(rd >= 32'd75 && rd <= 32'd85), 32'h1);
      // Bypass ignores the fine field; a low clock enable freezes the count
      apb(1, 8'h00, 32'h1F);
      apb(1, 8'h04, 32'h00);
      apb(1, 8'h04, 32'h30);
      pull_low <= 1'b1;
      idle(50);
      ce <= 1'b0;
      idle(100);
      ce <= 1'b1;
      idle(50);
      pull_low <= 1'b0;
      idle(4);
      apb(0, 8'h08, 32'h0);
      check(32'(rd >= 32'd45 && rd <= 32'd55), 32'h1);
      $display("prescaled measurement done");
      // Reset in arbitrate mode returns the control and prescale registers to zero
      tx_internal <= 1'b1;
      apb(1, 8'h04, 32'h90);
      rst_n <= 1'b0;
      idle(3);
      rst_n <= 1'b1;
      apb(0, 8'h04, 32'h0);
      check(rd, 32'h0);
      apb(0, 8'h00, 32'h0);
      check(rd, 32'h0);
      $display("reset done");
      conclude();
   end
endmodule // testbench

bind sfa_arbiter sfa_arbiter_properties chk (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .rxd_in(rxd_in), .tx_internal(tx_internal), .txd_out(txd_out), .irq(irq));

`default_nettype wire
